// ### hw/asp_pkg.sv
// Purpose: Shared constants and types for the converter serial host port
// Assumes: core_clk far faster than the serial clock (>= 4 samples per half period)
// Notes: Register indices travel in the 6-bit select field of the command byte
package asp_pkg;

   // ==========================================================
   // Command byte layout
   localparam int CMD_WEN_BIT = 7;
   localparam int CMD_RW_BIT = 6;
   localparam int SEL_W = 6;
   localparam int SHIFT_W = 24;
   localparam logic [4:0] CMD_BITS = 5'h08;

   // ==========================================================
   // Register indices
   localparam logic [5:0] SEL_STATUS = 6'h00;
   localparam logic [5:0] SEL_MODE = 6'h01;
   localparam logic [5:0] SEL_DATA = 6'h04;
   localparam logic [5:0] SEL_IOCTL = 6'h06;

   localparam logic [4:0] W_STATUS = 5'h08;
   localparam logic [4:0] W_MODE = 5'h10;
   localparam logic [4:0] W_DATA = 5'h18;
   localparam logic [4:0] W_IOCTL = 5'h10;

   // ==========================================================
   // Field positions and reset values
   localparam int STAT_RDY_N_BIT = 7;
   localparam int STAT_ERR_BIT = 6;
   localparam int MODE_CLK_LSB = 2;
   localparam int IO_PWR_SW_BIT = 1;
   localparam int IO_ERR_LVL_BIT = 3;
   localparam int IO_ERR_MODE_LSB = 4;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] IOCTL_RST = 16'h0000;
   // Pin sync order: sclk, cs_n, din, err; idle levels 0,1,0,1
   localparam int NSYNC = 4;
   localparam logic [3:0] SYNC_RST = 4'hA;

   typedef enum logic [1:0] {
      ERR_OFF = 2'h0,
      ERR_IN = 2'h1,
      ERR_OD = 2'h2,
      ERR_GPO = 2'h3
   } asp_err_mode_t;

   typedef enum logic [1:0] {
      CLK_INT = 2'h0,
      CLK_INT_OUT = 2'h1,
      CLK_EXT = 2'h2,
      CLK_XTAL = 2'h3
   } asp_clk_sel_t;

   typedef enum logic [2:0] {
      ST_CMD = 3'b001,
      ST_WR = 3'b010,
      ST_RD = 3'b100
   } asp_state_t;

endpackage

// ### hw/asp_stream_if.sv
// Purpose: Valid/ready word channel between converter core and the port
// Assumes: One clock domain, core_clk
// Notes: Word moves when valid and ready are both high
`timescale 1ns/1ps
interface asp_stream_if;
   logic valid;
   logic ready;
   logic [23:0] data;
   modport prod (output valid, output data, input ready);
   modport cons (input valid, input data, output ready);
endinterface

// ### hw/asp_buf2.sv
// Purpose: Two-entry result buffer with valid/ready on both sides
// Assumes: Both sides on core_clk
// Notes: Read data comes straight from the entry registers
`timescale 1ns/1ps
module asp_buf2 (
   input wire logic core_clk, // Core clock
   input wire logic arst_n, // Async reset, active low
   asp_stream_if.cons up, // Filling side
   asp_stream_if.prod dn // Draining side
);
   logic [23:0] mem_reg [2];
   logic [23:0] mem_next [2];
   logic wp_reg, wp_next, rp_reg, rp_next;
   logic [1:0] cnt_reg, cnt_next;
   logic push, pop;

   assign up.ready = (cnt_reg != 2'h2);
   assign dn.valid = (cnt_reg != 2'h0);
   assign dn.data = mem_reg[rp_reg];

   always_comb begin
      push = up.valid && up.ready;
      pop = dn.valid && dn.ready;
      mem_next = mem_reg;
      if (push) begin
         mem_next[wp_reg] = up.data;
      end
      wp_next = wp_reg ^ push;
      rp_next = rp_reg ^ pop;
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_reg[0] <= 24'h000000;
         mem_reg[1] <= 24'h000000;
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         mem_reg <= mem_next;
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   full_stall_a: assert property (@(posedge core_clk) disable iff (!arst_n)
      cnt_reg == 2'h2 |-> !up.ready && dn.valid)
      else $error("buffer full but still accepting");
endmodule

// ### hw/asp_adc_port.sv
// Purpose: Serial host port of the converter with ready indicator and pin control
// Assumes: sclk, cs_n, din and err_in come from pins; core_clk oversamples sclk
// Notes: Command byte bit7 must be 0, bit6 selects read, bits 5:0 select the register
// Functional notes
// [RL1] Output bits change on serial clock falling edge, sampled on rising.
// [RL2] Host sets input bit up before rising edge; device captures on rising.
// [RL3] Chip select high puts output and ready pin in high impedance.
// [RL4] Selected and idle, the output pin shows ready, low on new result.
// [RL5] Unread result: ready returns high before the next result loads.
// [RL6] Written data goes to the register named by the select field.
// [RL7] Any data or control register can load the output shift register.
// [RL8] Chip select active low; tied low gives a three-wire port.
// [RL9] Host may treat ready falling edge as a result-available interrupt.
// [RL10] Error pin in input mode: low level sets the converter error flag.
// [RL11] Open-drain error mode pulls the pin low while any error is set.
// [RL12] Output error mode drives the error pin level bit, actively.
// [RL13] Power-down switch follows its bit in the I/O control register.
// [RL14] Crystal clock pin role follows the mode register clock source field.
// [RL15] Host keeps chip select low and waits for ready before reading.
`timescale 1ns/1ps
module asp_adc_port
   import asp_pkg::*;
(
   input wire logic core_clk, // Core clock, 125 MHz
   input wire logic arst_n, // Async reset, active low
   input wire logic sclk, // Serial clock pin
   input wire logic cs_n, // Chip select pin, active low
   input wire logic din, // Serial data in pin
   output logic dout, // Serial data out / ready pin level
   output logic dout_oe_n, // Output enable, low while driving
   input wire logic err_in, // Error pin input level
   output logic err_out, // Error pin output level
   output logic err_oe_n, // Error pin enable, low while driving
   input wire logic conv_valid, // Converter result valid
   input wire logic [23:0] conv_data, // Converter result word
   output logic conv_ready, // Port can take a result
   output logic power_down_switch, // Power-down switch closed when high
   output logic xtal_enable, // Crystal oscillator on crystal pins
   output logic ext_clk_select, // Crystal clock pin is a clock input
   output logic clk_out_enable // Crystal clock pin drives the clock out
);

   // ==========================================================
   // Pin synchronisers
   logic [NSYNC-1:0] pin_raw, meta_reg, sync_reg;
   assign pin_raw = {err_in, din, cs_n, sclk};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               meta_reg[gi] <= SYNC_RST[gi];
               sync_reg[gi] <= SYNC_RST[gi];
            end else begin
               meta_reg[gi] <= pin_raw[gi];
               sync_reg[gi] <= meta_reg[gi];
            end
         end
      end
   endgenerate

   logic sclk_s, cs_s, din_s, err_s;
   assign sclk_s = sync_reg[0];
   assign cs_s = sync_reg[1];
   assign din_s = sync_reg[2];
   assign err_s = sync_reg[3];

   function automatic logic [4:0] reg_width(input logic [5:0] sel);
      unique case (sel)
         SEL_MODE: reg_width = W_MODE;
         SEL_DATA: reg_width = W_DATA;
         SEL_IOCTL: reg_width = W_IOCTL;
         default: reg_width = W_STATUS;
      endcase
   endfunction

   // ==========================================================
   // Result buffer
   asp_stream_if up_if ();
   asp_stream_if dn_if ();
   assign up_if.valid = conv_valid;
   assign up_if.data = conv_data;
   assign conv_ready = up_if.ready;

   asp_buf2 u_buf (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .up(up_if.cons),
      .dn(dn_if.prod)
   );

   // ==========================================================
   // Serial engine and registers
   asp_state_t state_reg, state_next;
   logic sclk_d_reg, sclk_d_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [5:0] sel_reg, sel_next;
   logic [23:0] shift_reg, shift_next;
   logic dout_reg, dout_next;
   logic oe_n_reg, oe_n_next;
   logic [15:0] mode_reg, mode_next;
   logic [15:0] io_control_reg, io_control_next;
   logic [23:0] data_reg, data_next;
   logic dvalid_reg, dvalid_next;
   logic adc_err_reg, adc_err_next;
   logic err_out_reg, err_out_next;
   logic err_oe_n_reg, err_oe_n_next;
   logic rise, fall, rd_data_busy, rd_data_done, status_read;
   logic [23:0] shifted;
   logic [4:0] cnt_inc;
   logic [7:0] status_val;
   asp_err_mode_t err_mode;
   asp_clk_sel_t clk_sel;

   assign rise = sclk_s && !sclk_d_reg;
   assign fall = !sclk_s && sclk_d_reg;
   assign rd_data_busy = (state_reg == ST_RD) && (sel_reg == SEL_DATA);
   assign dn_if.ready = !dvalid_reg && !rd_data_busy;
   assign err_mode = asp_err_mode_t'(io_control_reg[IO_ERR_MODE_LSB +: 2]);
   assign clk_sel = asp_clk_sel_t'(mode_reg[MODE_CLK_LSB +: 2]);

   always_comb begin
      state_next = state_reg;
      sclk_d_next = sclk_s;
      cnt_next = cnt_reg;
      sel_next = sel_reg;
      shift_next = shift_reg;
      mode_next = mode_reg;
      io_control_next = io_control_reg;
      rd_data_done = 1'b0;
      status_read = 1'b0;
      shifted = {shift_reg[22:0], din_s};
      cnt_inc = cnt_reg + 5'h01;
      status_val = 8'h00;
      status_val[STAT_RDY_N_BIT] = !dvalid_reg;
      status_val[STAT_ERR_BIT] = adc_err_reg;
      if (cs_s) begin
         // Deselect aborts any frame; tied low never aborts
         state_next = ST_CMD; // RL8
         cnt_next = 5'h00;
      end else if (rise) begin
         cnt_next = cnt_inc;
         unique case (state_reg)
            ST_CMD: begin
               shift_next = shifted; // RL2
               if (cnt_inc == CMD_BITS) begin
                  cnt_next = 5'h00;
                  sel_next = shifted[SEL_W-1:0];
                  if (shifted[CMD_WEN_BIT]) begin
                     state_next = ST_CMD;
                  end else if (shifted[CMD_RW_BIT]) begin
                     state_next = ST_RD;
                     status_read = (shifted[SEL_W-1:0] == SEL_STATUS);
                     unique case (shifted[SEL_W-1:0]) // RL7
                        SEL_STATUS: shift_next = {status_val, 16'h0000};
                        SEL_MODE: shift_next = {mode_reg, 8'h00};
                        SEL_IOCTL: shift_next = {io_control_reg, 8'h00};
                        SEL_DATA: shift_next = data_reg;
                        default: shift_next = 24'h000000;
                     endcase
                  end else begin
                     state_next = ST_WR;
                  end
               end
            end
            ST_WR: begin
               shift_next = shifted; // RL2
               if (cnt_inc == reg_width(sel_reg)) begin
                  state_next = ST_CMD;
                  cnt_next = 5'h00;
                  if (sel_reg == SEL_MODE) begin
                     mode_next = shifted[15:0]; // RL6
                  end
                  if (sel_reg == SEL_IOCTL) begin
                     io_control_next = shifted[15:0]; // RL6
                  end
               end
            end
            ST_RD: begin
               if (cnt_inc == reg_width(sel_reg)) begin
                  state_next = ST_CMD;
                  cnt_next = 5'h00;
                  rd_data_done = (sel_reg == SEL_DATA);
               end
            end
            default: state_next = ST_CMD;
         endcase
      end else if (fall && state_reg == ST_RD) begin
         shift_next = {shift_reg[22:0], 1'b0};
      end
   end

   always_comb begin
      data_next = data_reg;
      dvalid_next = dvalid_reg;
      if (rd_data_done) begin
         dvalid_next = 1'b0;
      end else if (dn_if.valid && dn_if.ready) begin
         data_next = dn_if.data;
         dvalid_next = 1'b1; // RL4
      end else if (dn_if.valid && dvalid_reg && !rd_data_busy) begin
         // Stale result: raise ready one cycle before replacing it
         dvalid_next = 1'b0; // RL5
      end
      // Pin level changes on falling edge only while shifting out
      dout_next = dout_reg;
      if (state_reg == ST_RD) begin
         if (fall) begin
            dout_next = shift_reg[23]; // RL1
         end
      end else begin
         dout_next = !dvalid_next; // RL4
      end
      oe_n_next = cs_s; // RL3
      // Set wins over the clear caused by a status read
      adc_err_next = adc_err_reg && !status_read;
      if (err_mode == ERR_IN && !err_s) begin
         adc_err_next = 1'b1; // RL10
      end
      unique case (err_mode)
         ERR_OD: begin
            err_out_next = 1'b0;
            err_oe_n_next = !adc_err_next; // RL11
         end
         ERR_GPO: begin
            err_out_next = io_control_reg[IO_ERR_LVL_BIT]; // RL12
            err_oe_n_next = 1'b0;
         end
         default: begin
            err_out_next = 1'b0;
            err_oe_n_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_CMD;
         sclk_d_reg <= 1'b0;
         cnt_reg <= 5'h00;
         sel_reg <= 6'h00;
         shift_reg <= 24'h000000;
         dout_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         mode_reg <= MODE_RST;
         io_control_reg <= IOCTL_RST;
         data_reg <= 24'h000000;
         dvalid_reg <= 1'b0;
         adc_err_reg <= 1'b0;
         err_out_reg <= 1'b0;
         err_oe_n_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         sclk_d_reg <= sclk_d_next;
         cnt_reg <= cnt_next;
         sel_reg <= sel_next;
         shift_reg <= shift_next;
         dout_reg <= dout_next;
         oe_n_reg <= oe_n_next;
         mode_reg <= mode_next;
         io_control_reg <= io_control_next;
         data_reg <= data_next;
         dvalid_reg <= dvalid_next;
         adc_err_reg <= adc_err_next;
         err_out_reg <= err_out_next;
         err_oe_n_reg <= err_oe_n_next;
      end
   end

   // ==========================================================
   // Pin outputs
   assign dout = dout_reg;
   assign dout_oe_n = oe_n_reg;
   assign err_out = err_out_reg;
   assign err_oe_n = err_oe_n_reg;
   assign power_down_switch = io_control_reg[IO_PWR_SW_BIT]; // RL13
   assign xtal_enable = (clk_sel == CLK_XTAL); // RL14
   assign ext_clk_select = (clk_sel == CLK_EXT); // RL14
   assign clk_out_enable = (clk_sel == CLK_INT_OUT); // RL14

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   tristate_cs_a: assert property (cs_s |=> dout_oe_n) // RL3
      else $error("output driven while deselected");
   fall_only_a: assert property (state_reg == ST_RD && state_next == ST_RD && !fall |=> $stable(dout)) // RL1
      else $error("output bit moved without falling edge");
   rise_capture_a: assert property (state_reg == ST_CMD && !rise |=> $stable(shift_reg)) // RL2
      else $error("input captured without rising edge");
   ready_low_a: assert property (dn_if.valid && dn_if.ready && !cs_s && state_reg != ST_RD // RL4
      |=> dvalid_reg && data_reg == $past(dn_if.data) && !dout)
      else $error("ready not low after new result");
   ready_high_a: assert property (dn_if.valid && dvalid_reg && !rd_data_busy |=> !dvalid_reg ##1 dvalid_reg) // RL5
      else $error("stale result replaced without ready high");
   write_ioctl_a: assert property (state_reg == ST_WR && rise && !cs_s && sel_reg == SEL_IOCTL // RL6
      && cnt_inc == W_IOCTL |=> io_control_reg == $past(shifted[15:0]))
      else $error("register write lost");
   read_load_a: assert property (state_reg == ST_CMD && state_next == ST_RD && sel_next == SEL_MODE // RL7
      |=> shift_reg == {mode_reg, 8'h00})
      else $error("mode not loaded for shifting");
   err_input_a: assert property (err_mode == ERR_IN && !err_s |=> adc_err_reg) // RL10
      else $error("error input did not set flag");
   // Registered pin loads from the same next flag value as the flag, so compare in the same cycle
   err_drain_a: assert property (err_mode == ERR_OD && $stable(err_mode) // RL11
      |-> err_oe_n == !adc_err_reg && !err_out)
      else $error("open-drain error not pulled low");
   err_gpo_a: assert property (err_mode == ERR_GPO && $stable(io_control_reg) // RL12
      |-> !err_oe_n && err_out == io_control_reg[IO_ERR_LVL_BIT])
      else $error("error pin level mismatch");
   pwr_switch_a: assert property (state_reg == ST_WR && rise && !cs_s && sel_reg == SEL_IOCTL // RL13
      && cnt_inc == W_IOCTL |=> power_down_switch == $past(shifted[IO_PWR_SW_BIT]))
      else $error("power-down switch missed its write");
   clk_pin_a: assert property (state_reg == ST_WR && rise && !cs_s && sel_reg == SEL_MODE // RL14
      && cnt_inc == W_MODE |=> $onehot0({xtal_enable, ext_clk_select, clk_out_enable})
      && xtal_enable == ($past(shifted[MODE_CLK_LSB +: 2]) == CLK_XTAL)
      && ext_clk_select == ($past(shifted[MODE_CLK_LSB +: 2]) == CLK_EXT)
      && clk_out_enable == ($past(shifted[MODE_CLK_LSB +: 2]) == CLK_INT_OUT))
      else $error("clock pin role mismatch");
endmodule

// ### bench/asp_host_model.sv
// Purpose: Host serial master model for the converter port
// Assumes: Link half period 62.5 ns, steps taken on core_clk edges
// Notes: din shows the inverse of its last bit between frames
`timescale 1ns/1ps
module asp_host_model (
   input wire logic core_clk, // Core clock
   output logic sclk, // Serial clock, idle low
   output logic cs_n, // Chip select, active low
   output logic din, // Serial data to device
   input wire logic dout, // Serial data from device
   input wire logic dout_oe_n // Low while device drives dout
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // ==========================================================
   // Link timing
   task automatic half();
      realtime t;
      t = $realtime + 62.5;
      while ($realtime < t) @(posedge core_clk);
   endtask

   task automatic select(input logic v);
      half();
      cs_n <= v;
      half();
   endtask

   // MSB first; undriven dout reads back inverted, never as a lucky match
   task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         din <= tx[i];
         half();
         sclk <= 1'b1;
         rx = {rx[30:0], dout_oe_n ? ~dout : dout};
         half();
         sclk <= 1'b0;
      end
      din <= ~tx[0];
      half();
   endtask
endmodule

// ### bench/asp_adc_port_tb.sv
// Purpose: Self-checking bench for the converter serial host port
// Assumes: Host model drives the link; error line pulled up outside
// Notes: Chip select stays low between most frames (three-wire use)
`timescale 1ns/1ps
module asp_adc_port_tb
   import asp_pkg::*;
   ;
   logic core_clk = 1'b0;
   logic arst_n, err_ext, conv_valid, conv_ready;
   logic [23:0] conv_data, r;
   logic [31:0] junk;
   logic sclk, cs_n, din, dout, dout_oe_n, err_out, err_oe_n, err_pin;
   logic power_down_switch, xtal_enable, ext_clk_select, clk_out_enable;
   int errors = 0;
   int check_count = 0;
   int n, k;

   always #4 core_clk = ~core_clk;
   assign err_pin = !err_oe_n ? err_out : err_ext;

   asp_adc_port dut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .dout_oe_n(dout_oe_n), .err_in(err_pin), .err_out(err_out), .err_oe_n(err_oe_n),
      .conv_valid(conv_valid), .conv_data(conv_data), .conv_ready(conv_ready),
      .power_down_switch(power_down_switch), .xtal_enable(xtal_enable),
      .ext_clk_select(ext_clk_select), .clk_out_enable(clk_out_enable));

   asp_host_model host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
      .dout_oe_n(dout_oe_n));

   // ==========================================================
   // Checks and verdict
   task automatic chk1(input string m, input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %b", $time, m, got);
      end
   endtask

   task automatic chkw(input string m, input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h", $time, m, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Link access
   task automatic xf(input logic [7:0] cmd, input int w, input logic [23:0] v, output logic [23:0] q);
      logic [31:0] rx;
      host.shift((32'(cmd) << w) | 32'(v), 8 + w, rx);
      q = 24'(rx & ((32'h1 << w) - 32'h1));
   endtask

   task automatic wr(input logic [5:0] sel, input int w, input logic [23:0] v);
      logic [23:0] q;
      xf({2'b00, sel}, w, v, q);
   endtask

   task automatic rdc(input logic [5:0] sel, input int w, input logic [23:0] exp, input string m);
      logic [23:0] q;
      xf({2'b01, sel}, w, 24'h0, q);
      chkw(m, q, exp);
   endtask

   task automatic push(input logic [23:0] w);
      conv_valid <= 1'b1;
      conv_data <= w;
      @(posedge core_clk);
      conv_valid <= 1'b0;
   endtask

   task automatic wait_dout(input logic v);
      int c;
      c = 0;
      while (dout !== v && c < 2000) begin
         @(posedge core_clk);
         c++;
      end
      if (dout !== v) begin
         errors++;
         $display("unexpected at %0t: no ready change", $time);
         stop_test();
      end
   endtask

   // ==========================================================
   // Sequence
   initial begin
      arst_n = 1'b0;
      err_ext = 1'b1;
      conv_valid = 1'b0;
      conv_data = 24'h000000;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      #1;
      chk1("oe reset", dout_oe_n, 1'b1);
      chk1("power switch reset", power_down_switch, 1'b0);
      chk1("clkout reset", clk_out_enable, 1'b0);
      host.select(1'b0);
      chk1("oe selected", dout_oe_n, 1'b0);
      chk1("idle ready", dout, 1'b1);
      push(24'hA5C3E1);
      wait_dout(1'b0);
      rdc(SEL_DATA, W_DATA, 24'hA5C3E1, "data");
      chk1("ready cleared", dout, 1'b1);
      for (int c = 0; c < 4; c++) begin
         wr(SEL_MODE, W_MODE, 24'(c << MODE_CLK_LSB));
         chk1("xtal", xtal_enable, c == 3);
         chk1("ext", ext_clk_select, c == 2);
         chk1("clkout", clk_out_enable, c == 1);
         rdc(SEL_MODE, W_MODE, 24'(c << MODE_CLK_LSB), "mode");
      end
      wr(SEL_IOCTL, W_IOCTL, 24'h000002);
      chk1("power switch on", power_down_switch, 1'b1);
      wr(SEL_IOCTL, W_IOCTL, 24'h000038);
      chk1("gpo oe", err_oe_n, 1'b0);
      chk1("gpo high", err_out, 1'b1);
      wr(SEL_IOCTL, W_IOCTL, 24'h000030);
      chk1("gpo low", err_out, 1'b0);
      wr(SEL_IOCTL, W_IOCTL, 24'h000010);
      chk1("input oe", err_oe_n, 1'b1);
      err_ext <= 1'b0;
      repeat (8) @(posedge core_clk);
      err_ext <= 1'b1;
      wr(SEL_IOCTL, W_IOCTL, 24'h000020);
      chk1("od drive", err_oe_n, 1'b0);
      chk1("od low", err_out, 1'b0);
      rdc(SEL_STATUS, W_STATUS, 24'h0000C0, "status err");
      chk1("od release", err_oe_n, 1'b1);
      rdc(SEL_STATUS, W_STATUS, 24'h000080, "status clear");
      // Refused accesses leave state alone
      wr(SEL_DATA, W_DATA, 24'h123456);
      rdc(SEL_DATA, W_DATA, 24'hA5C3E1, "data kept");
      rdc(6'h02, 8, 24'h000000, "unmapped");
      xf(8'h80 | 8'(SEL_MODE), 0, 24'h0, r);
      rdc(SEL_MODE, W_MODE, 24'h00000C, "after bad cmd");
      host.shift(32'h00000008, 5, junk);
      host.select(1'b1);
      chk1("abort tristate", dout_oe_n, 1'b1);
      host.select(1'b0);
      rdc(SEL_MODE, W_MODE, 24'h00000C, "after abort");
      // Buffer fills while a data read stalls loads
      push(24'h000111);
      wait_dout(1'b0);
      fork
         rdc(SEL_DATA, W_DATA, 24'h000111, "held word");
         begin
            repeat (150) @(posedge core_clk);
            n = 0;
            conv_data <= 24'h000222;
            conv_valid <= 1'b1;
            for (k = 0; k < 6; k++) begin
               @(posedge core_clk);
               if (conv_ready) begin
                  n++;
                  conv_data <= 24'h000222 + 24'(n);
               end
            end
            conv_valid <= 1'b0;
            chkw("accepted", 24'(n), 24'h000002);
            chk1("full", conv_ready, 1'b0);
         end
      join
      repeat (10) @(posedge core_clk);
      wait_dout(1'b0);
      chk1("drained", conv_ready, 1'b1);
      rdc(SEL_DATA, W_DATA, 24'h000223, "newest word");
      host.select(1'b1);
      chk1("end tristate", dout_oe_n, 1'b1);
      stop_test();
   end
endmodule
